// [rtl/cpuf_pkg.sv]
// Shared constants, operation codes and carriers of the core register set
`default_nettype none

package cpuf_pkg;

  // Flag positions in the processor status byte
  localparam int BIT_C = 0;  // Carry
  localparam int BIT_Z = 1;  // Zero
  localparam int BIT_I = 2;  // Interrupt disable
  localparam int BIT_D = 3;  // Decimal mode
  localparam int BIT_B = 4;  // Break, only ever set in a pushed copy
  localparam int BIT_T = 5;  // Memory-to-memory index mode
  localparam int BIT_V = 6;  // Overflow
  localparam int BIT_N = 7;  // Negative

  // Bit-test copies these operand bits
  localparam int TEST_V_BIT = 6;
  localparam int TEST_N_BIT = 7;

  // Reset values; only the interrupt disable flag is set, all other flags reset clear
  localparam logic [7:0] STATUS_RESET = 8'h04;
  localparam logic [7:0] STACK_RESET = 8'hff;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;

  // Byte masks
  localparam logic [7:0] BREAK_MASK = 8'h10;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] WORD_ONE = 16'h0001;

  // Memory-to-memory destination lives in the zero page
  localparam logic [7:0] ZERO_PAGE_HIGH = 8'h00;

  // Decimal correction constants
  localparam logic [4:0] DEC_LIMIT = 5'h09;
  localparam logic [4:0] DEC_FIX_NIB = 5'h06;
  localparam logic [7:0] DEC_FIX_LO = 8'h06;
  localparam logic [7:0] DEC_FIX_HI = 8'h60;

  // Operations presented by the instruction sequencer
  typedef enum logic [5:0] {
    OP_NOP, OP_PC_STEP, OP_JUMP, OP_LOAD_ACC, OP_LOAD_IDX1, OP_LOAD_IDX2, OP_LOAD_STACK,
    OP_ADD, OP_SUB, OP_SHIFT_L, OP_SHIFT_R, OP_ROT_L, OP_ROT_R, OP_BIT_TEST,
    OP_CARRY_SET, OP_CARRY_CLEAR, OP_MASK_ON, OP_MASK_OFF, OP_DECIMAL_ON, OP_DECIMAL_OFF,
    OP_MEM_MODE_ON, OP_MEM_MODE_OFF, OP_OVERFLOW_CLEAR,
    OP_PUSH_ACC, OP_POP_ACC, OP_PUSH_STATUS, OP_POP_STATUS,
    OP_SOFTWARE_BREAK, OP_CALL, OP_RETURN_SUB, OP_RETURN_INT,
    OP_PRODUCT, OP_DIVIDE, OP_WAIT_INT, OP_CLOCK_HALT, OP_FIELD_STORE, OP_FIELD_SHIFT
  } cpuf_op_e;

  // Stack memory port: asynchronous read, write on the clock edge
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wrData;
    logic write;
    logic read;
  } cpuf_stack_s;

  // Memory-to-memory result write
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic write;
  } cpuf_mem_s;

endpackage : cpuf_pkg

`default_nettype wire

// [rtl/cpuf_alu.sv]
// Eight-bit adder and subtracter with binary and decimal modes
`default_nettype none

module cpuf_alu
  import cpuf_pkg::*;
(
  input wire logic [7:0] opA,  // First operand
  input wire logic [7:0] opB,  // Second operand
  input wire logic carryIn,  // Carry, or inverted borrow when subtracting
  input wire logic subtract,  // High for subtract-with-borrow
  input wire logic decimal,  // High for decimal arithmetic
  output logic [7:0] result,  // Corrected result
  output logic carryOut,  // Carry, or inverted borrow
  output logic overflow  // Signed range exceeded
);

  logic [7:0] bOp;  // Operand B, inverted for subtract
  logic [8:0] binSum;  // Plain binary sum with carry
  logic [4:0] lowSum;  // Low digit work value
  logic [4:0] highSum;  // High digit work value
  logic [4:0] lowDiff;  // Low digit borrow probe

  // Binary path is always formed; decimal paths correct from it or per digit
  always_comb begin
    bOp = subtract ? ~opB : opB;
    binSum = {1'b0, opA} + {1'b0, bOp} + {8'h00, carryIn};
    // Signed overflow: equal input signs, different result sign
    overflow = (opA[7] == bOp[7]) && (binSum[7] != opA[7]);
    lowSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    lowDiff = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, ~carryIn};
    highSum = 5'h00;
    result = binSum[7:0];
    carryOut = binSum[8];
    if (decimal && !subtract) begin
      // Digit-wise add with automatic correction above nine
      if (lowSum > DEC_LIMIT) begin
        lowSum = lowSum + DEC_FIX_NIB;
      end
      highSum = {1'b0, opA[7:4]} + {1'b0, opB[7:4]} + {4'h0, lowSum[4]};
      if (highSum > DEC_LIMIT) begin
        highSum = highSum + DEC_FIX_NIB;
      end
      result = {highSum[3:0], lowSum[3:0]};
      carryOut = highSum[4];
    end else if (decimal) begin
      // Subtract in binary, then take six from each digit that borrowed
      if (lowDiff[4]) begin
        result = result - DEC_FIX_LO;
      end
      if (!binSum[8]) begin
        result = result - DEC_FIX_HI;
      end
    end
  end

endmodule : cpuf_alu

`default_nettype wire

// [rtl/cpuf_registers.sv]
// Programmer-visible registers, status flags and stack sequencing of the core
`default_nettype none

// How it works
// - Eight-bit accumulator holds operands and results.
// - Two index registers; indexed address adds operand.
// - Index mode: first index addresses first operand.
// - Stack pointer gives low stack address byte.
// - Page bit selects stack page zero or one.
// - Sixteen-bit counter from high and low halves.
// - Calls push return address; interrupts also status.
// - Eight-bit status; decimal mode invalidates Z,V,N.
// - Reset sets interrupt disable flag.
// - Carry from adder, shifts and rotates.
// - Zero flag follows zero result.
// - Disable flag blocks all but software break.
// - Accepting interrupt sets disable flag.
// - Decimal flag selects decimal add/subtract only.
// - Live break reads zero; break push carries one.
// - Index mode stores result at first index.
// - Overflow flags signed range beyond +127/-128.
// - Bit test copies bits 6,7 to V,N.
// - Negative flag follows negative result.
// - Dedicated flag set and clear operations.
// - Push and pop of accumulator and status.
// - No field ops; multiply, divide, wait, halt exist.
module cpuf_registers
  import cpuf_pkg::*;
#(
  parameter logic [7:0] STACK_INIT = STACK_RESET,  // Stack pointer after reset
  parameter logic [15:0] COUNTER_INIT = COUNTER_RESET  // Program counter after reset
) (
  input wire logic clk,  // Core clock
  input wire logic rst_b,  // Synchronous reset, active low
  input wire logic opValid,  // Operation request
  input wire cpuf_op_e op,  // Operation to perform
  input wire logic [7:0] operand,  // Immediate or memory data
  input wire logic [15:0] target,  // Jump or call destination
  input wire logic [15:0] operandAddr,  // Base address for indexed modes
  input wire logic idxSel,  // Index select: 0 first, 1 second
  input wire logic [7:0] memAtFirst,  // Memory byte addressed by first index
  input wire logic stackPage,  // Stack page selection bit
  input wire logic [7:0] stackRdData,  // Stack read data, same cycle
  input wire logic irqReq,  // Maskable interrupt request, level
  input wire logic [15:0] vectorAddr,  // Service routine address
  output logic opTaken,  // Request accepted this cycle
  output logic busy,  // Sequencer is stacking or unstacking
  output logic irqAck,  // Interrupt accepted this cycle
  output logic illegalOp,  // Unsupported operation or zero divisor, pulse
  output logic [15:0] indexedAddr,  // Base plus selected index
  output logic [15:0] secondOpAddr,  // Operand address in index mode
  output cpuf_stack_s stackBus,  // Stack memory port
  output cpuf_mem_s memBus,  // Index mode result write
  output logic [7:0] accumulator,  // Accumulator
  output logic [7:0] indexRegFirst,  // First index register
  output logic [7:0] indexRegSecond,  // Second index register
  output logic [7:0] stackIndex,  // Stack pointer
  output logic [7:0] counterHighHalf,  // Program counter high half
  output logic [7:0] counterLowHalf,  // Program counter low half
  output logic [7:0] processorStatus,  // Live status, break bit always zero
  output logic nzvValid,  // Zero, overflow, negative meaningful
  output logic waiting,  // Waiting for an interrupt
  output logic halted  // Clock stopped
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_PS, ST_POP_PS, ST_POP_LO, ST_POP_HI,
    ST_WAIT, ST_HALT
  } cpuf_state_e;

  cpuf_state_e state;  // Sequencer state
  cpuf_state_e next_state;  // Sequencer next state
  logic [15:0] pendingTarget;  // Counter value loaded after stacking
  logic withStatus;  // Stacking also saves status
  logic breakEntry;  // Entry caused by the software break
  logic irqTake;  // Accept a maskable interrupt now
  logic take;  // Accept the requested operation now
  logic tMode;  // Memory-to-memory mode active
  logic [7:0] aluA;  // Adder first operand
  logic [7:0] aluRes;  // Adder result
  logic aluCarry;  // Adder carry out
  logic aluOvf;  // Adder overflow
  logic [7:0] shiftRes;  // Shift or rotate result
  logic shiftCarry;  // Bit shifted out
  logic [15:0] product;  // Accumulator times operand
  logic [15:0] quotient;  // Double byte over operand
  logic [15:0] remainder;  // Remainder of the division
  logic [7:0] flags;  // Stored flags, break kept clear

  // Stack address: pointer in the low byte, page bit in the high byte
  function automatic logic [15:0] stackAddrOf(input logic page, input logic [7:0] ptr);
    stackAddrOf = {7'h00, page, ptr};
  endfunction

  // Zero check used by several flag updates
  function automatic logic isZero(input logic [7:0] value);
    isZero = (value == BYTE_ZERO);
  endfunction

  // The break bit never lives in the stored flags
  assign processorStatus = flags & ~BREAK_MASK;
  assign nzvValid = ~flags[BIT_D];
  assign tMode = flags[BIT_T];
  assign busy = (state != ST_IDLE) && (state != ST_WAIT) && (state != ST_HALT);
  assign waiting = (state == ST_WAIT);
  assign halted = (state == ST_HALT);

  // Interrupts are sampled only between operations; disable flag masks them
  assign irqTake = (state == ST_IDLE) && irqReq && !flags[BIT_I];
  assign take = (state == ST_IDLE) && opValid && !irqTake;
  assign opTaken = take;
  assign irqAck = irqTake;

  // Indexed and memory-to-memory addressing
  assign indexedAddr = operandAddr + {8'h00, idxSel ? indexRegSecond : indexRegFirst};
  assign secondOpAddr = {ZERO_PAGE_HIGH, indexRegFirst};

  // In index mode the first operand is memory at the first index
  assign aluA = tMode ? memAtFirst : accumulator;

  cpuf_alu u_alu (
    .opA(aluA),
    .opB(operand),
    .carryIn(flags[BIT_C]),
    .subtract(op == OP_SUB),
    .decimal(flags[BIT_D]),
    .result(aluRes),
    .carryOut(aluCarry),
    .overflow(aluOvf)
  );

  // Shifts and rotates act on the accumulator
  always_comb begin
    shiftRes = accumulator;
    shiftCarry = flags[BIT_C];
    case (op)
      OP_SHIFT_L: begin
        shiftRes = {accumulator[6:0], 1'b0};
        shiftCarry = accumulator[7];
      end
      OP_SHIFT_R: begin
        shiftRes = {1'b0, accumulator[7:1]};
        shiftCarry = accumulator[0];
      end
      OP_ROT_L: begin
        shiftRes = {accumulator[6:0], flags[BIT_C]};
        shiftCarry = accumulator[7];
      end
      OP_ROT_R: begin
        shiftRes = {flags[BIT_C], accumulator[7:1]};
        shiftCarry = accumulator[0];
      end
      default: begin
        shiftRes = accumulator;
      end
    endcase
  end

  // Multiply and divide; a zero divisor leaves the registers alone
  always_comb begin
    product = {8'h00, accumulator} * {8'h00, operand};
    quotient = {indexRegSecond, accumulator};
    remainder = 16'h0000;
    if (!isZero(operand)) begin
      quotient = {indexRegSecond, accumulator} / {8'h00, operand};
      remainder = {indexRegSecond, accumulator} % {8'h00, operand};
    end
  end

  // Stack port; single-byte pushes and pops finish in their request cycle
  always_comb begin
    stackBus = '0;
    case (state)
      ST_IDLE: begin
        if (take && (op == OP_PUSH_ACC || op == OP_PUSH_STATUS)) begin
          stackBus.addr = stackAddrOf(stackPage, stackIndex);
          stackBus.write = 1'b1;
          // A plain status push never carries the break bit
          stackBus.wrData = (op == OP_PUSH_ACC) ? accumulator : processorStatus;
        end else if (take && (op == OP_POP_ACC || op == OP_POP_STATUS)) begin
          stackBus.addr = stackAddrOf(stackPage, stackIndex + BYTE_ONE);
          stackBus.read = 1'b1;
        end
      end
      ST_PUSH_HI: begin
        stackBus.addr = stackAddrOf(stackPage, stackIndex);
        stackBus.wrData = counterHighHalf;
        stackBus.write = 1'b1;
      end
      ST_PUSH_LO: begin
        stackBus.addr = stackAddrOf(stackPage, stackIndex);
        stackBus.wrData = counterLowHalf;
        stackBus.write = 1'b1;
      end
      ST_PUSH_PS: begin
        stackBus.addr = stackAddrOf(stackPage, stackIndex);
        // Only the copy saved by the software break shows the break bit
        stackBus.wrData = breakEntry ? (processorStatus | BREAK_MASK) : processorStatus;
        stackBus.write = 1'b1;
      end
      ST_POP_PS, ST_POP_LO, ST_POP_HI: begin
        stackBus.addr = stackAddrOf(stackPage, stackIndex + BYTE_ONE);
        stackBus.read = 1'b1;
      end
      default: begin
        stackBus = '0;
      end
    endcase
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (irqTake) begin
          next_state = ST_PUSH_HI;
        end else if (take) begin
          case (op)
            OP_SOFTWARE_BREAK, OP_CALL: next_state = ST_PUSH_HI;
            OP_RETURN_INT: next_state = ST_POP_PS;
            OP_RETURN_SUB: next_state = ST_POP_LO;
            OP_WAIT_INT: next_state = ST_WAIT;
            OP_CLOCK_HALT: next_state = ST_HALT;
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_PUSH_HI: next_state = ST_PUSH_LO;
      ST_PUSH_LO: next_state = withStatus ? ST_PUSH_PS : ST_IDLE;
      ST_PUSH_PS: next_state = ST_IDLE;
      ST_POP_PS: next_state = ST_POP_LO;
      ST_POP_LO: next_state = ST_POP_HI;
      ST_POP_HI: next_state = ST_IDLE;
      // Any request wakes the core; a masked one then simply resumes
      ST_WAIT, ST_HALT: next_state = irqReq ? ST_IDLE : state;
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer state and the entry kind it is working on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      pendingTarget <= COUNTER_RESET;
      withStatus <= 1'b0;
      breakEntry <= 1'b0;
    end else begin
      state <= next_state;
      if (irqTake) begin
        pendingTarget <= vectorAddr;
        withStatus <= 1'b1;
        breakEntry <= 1'b0;
      end else if (take && op == OP_SOFTWARE_BREAK) begin
        // Break is honoured even with the disable flag set
        pendingTarget <= vectorAddr;
        withStatus <= 1'b1;
        breakEntry <= 1'b1;
      end else if (take && op == OP_CALL) begin
        pendingTarget <= target;
        withStatus <= 1'b0;
        breakEntry <= 1'b0;
      end
    end
  end

  // Stack pointer and program counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stackIndex <= STACK_INIT;
      {counterHighHalf, counterLowHalf} <= COUNTER_INIT;
    end else begin
      if (stackBus.write) begin
        stackIndex <= stackIndex - BYTE_ONE;
      end else if (stackBus.read) begin
        stackIndex <= stackIndex + BYTE_ONE;
      end else if (take && op == OP_LOAD_STACK) begin
        stackIndex <= operand;
      end
      if ((state == ST_PUSH_LO && !withStatus) || state == ST_PUSH_PS) begin
        {counterHighHalf, counterLowHalf} <= pendingTarget;
      end else if (state == ST_POP_LO) begin
        counterLowHalf <= stackRdData;
      end else if (state == ST_POP_HI) begin
        counterHighHalf <= stackRdData;
      end else if (take && op == OP_JUMP) begin
        {counterHighHalf, counterLowHalf} <= target;
      end else if (take && op == OP_PC_STEP) begin
        {counterHighHalf, counterLowHalf} <= {counterHighHalf, counterLowHalf} + WORD_ONE;
      end
    end
  end

  // Accumulator and index registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      accumulator <= BYTE_ZERO;
      indexRegFirst <= BYTE_ZERO;
      indexRegSecond <= BYTE_ZERO;
    end else if (take) begin
      case (op)
        OP_LOAD_ACC: accumulator <= operand;
        OP_LOAD_IDX1: indexRegFirst <= operand;
        OP_LOAD_IDX2: indexRegSecond <= operand;
        // Index mode sends the result to memory, not the accumulator
        OP_ADD, OP_SUB: accumulator <= tMode ? accumulator : aluRes;
        OP_SHIFT_L, OP_SHIFT_R, OP_ROT_L, OP_ROT_R: accumulator <= shiftRes;
        OP_POP_ACC: accumulator <= stackRdData;
        OP_PRODUCT: {indexRegSecond, accumulator} <= product;
        OP_DIVIDE: begin
          if (!isZero(operand)) begin
            accumulator <= quotient[7:0];
            indexRegSecond <= remainder[7:0];
          end
        end
        default: accumulator <= accumulator;
      endcase
    end
  end

  // Index mode result write and the refusal pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      memBus <= '0;
      illegalOp <= 1'b0;
    end else begin
      memBus.write <= take && tMode && (op == OP_ADD || op == OP_SUB);
      memBus.addr <= secondOpAddr;
      memBus.data <= aluRes;
      // Field operations are absent from this core
      illegalOp <= take && (op == OP_FIELD_STORE || op == OP_FIELD_SHIFT ||
                           (op == OP_DIVIDE && isZero(operand)));
    end
  end

  // Status flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags <= STATUS_RESET;
    end else if (irqTake) begin
      flags[BIT_I] <= 1'b1;
    end else if (state == ST_POP_PS) begin
      flags <= stackRdData & ~BREAK_MASK;
    end else if (take) begin
      case (op)
        OP_ADD, OP_SUB: begin
          flags[BIT_C] <= aluCarry;
          flags[BIT_V] <= aluOvf;
          flags[BIT_Z] <= isZero(aluRes);
          flags[BIT_N] <= aluRes[7];
        end
        OP_SHIFT_L, OP_SHIFT_R, OP_ROT_L, OP_ROT_R: begin
          flags[BIT_C] <= shiftCarry;
          flags[BIT_Z] <= isZero(shiftRes);
          flags[BIT_N] <= shiftRes[7];
        end
        OP_LOAD_ACC, OP_LOAD_IDX1, OP_LOAD_IDX2: begin
          flags[BIT_Z] <= isZero(operand);
          flags[BIT_N] <= operand[7];
        end
        OP_POP_ACC: begin
          flags[BIT_Z] <= isZero(stackRdData);
          flags[BIT_N] <= stackRdData[7];
        end
        OP_BIT_TEST: begin
          flags[BIT_V] <= operand[TEST_V_BIT];
          flags[BIT_N] <= operand[TEST_N_BIT];
          flags[BIT_Z] <= isZero(accumulator & operand);
        end
        OP_CARRY_SET: flags[BIT_C] <= 1'b1;
        OP_CARRY_CLEAR: flags[BIT_C] <= 1'b0;
        OP_MASK_ON: flags[BIT_I] <= 1'b1;
        OP_MASK_OFF: flags[BIT_I] <= 1'b0;
        OP_DECIMAL_ON: flags[BIT_D] <= 1'b1;
        OP_DECIMAL_OFF: flags[BIT_D] <= 1'b0;
        OP_MEM_MODE_ON: flags[BIT_T] <= 1'b1;
        OP_MEM_MODE_OFF: flags[BIT_T] <= 1'b0;
        OP_OVERFLOW_CLEAR: flags[BIT_V] <= 1'b0;
        OP_POP_STATUS: flags <= stackRdData & ~BREAK_MASK;
        OP_SOFTWARE_BREAK: flags[BIT_I] <= 1'b1;
        default: flags <= flags;
      endcase
    end
  end

endmodule : cpuf_registers

`default_nettype wire

// [testbench/cpuf_registers_properties.sv]
// Concurrent checks on the core register set ports
`default_nettype none
module cpuf_registers_check
  import cpuf_pkg::*;
(
  input wire logic clk,  // Core clock
  input wire logic rst_b,  // Reset, active low
  input wire cpuf_op_e op,  // Operation code
  input wire logic [7:0] operand,  // Operand byte
  input wire logic stackPage,  // Stack page bit
  input wire logic opTaken,  // Take strobe
  input wire logic busy,  // Stacking in progress
  input wire logic irqAck,  // Interrupt accepted
  input wire logic illegalOp,  // Unsupported op pulse
  input wire cpuf_stack_s stackBus,  // Stack port
  input wire logic [7:0] accumulator,  // Accumulator
  input wire logic [7:0] processorStatus,  // Live flags
  input wire logic nzvValid  // Zero, overflow, negative meaningful
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Break mark lives only in the pushed copy
  property p_brk; processorStatus[BIT_B] == 1'b0; endproperty
  a_brk: assert property (p_brk) else $error("live break flag set");
  property p_rst; $rose(rst_b) |-> processorStatus[BIT_I]; endproperty
  a_rst: assert property (p_rst) else $error("mask flag clear after reset");
  // Load result and its flags land one cycle after the take
  property p_ld; opTaken && op == OP_LOAD_ACC |=> accumulator == $past(operand)
    && processorStatus[BIT_Z] == (accumulator == 8'h00)
    && processorStatus[BIT_N] == accumulator[7]; endproperty
  a_ld: assert property (p_ld) else $error("load result or flags wrong");
  property p_ack; irqAck |=> processorStatus[BIT_I]; endproperty
  a_ack: assert property (p_ack) else $error("mask not set on accept");
  property p_mask; processorStatus[BIT_I] |-> !irqAck; endproperty
  a_mask: assert property (p_mask) else $error("interrupt taken while masked");
  property p_nzv; nzvValid == !processorStatus[BIT_D]; endproperty
  a_nzv: assert property (p_nzv) else $error("validity does not follow decimal");
  property p_page; stackBus.write |-> stackBus.addr[15:8] == {7'h00, stackPage}; endproperty
  a_page: assert property (p_page) else $error("stack page wrong");
  property p_fld; opTaken && op == OP_FIELD_STORE |=> illegalOp; endproperty
  a_fld: assert property (p_fld) else $error("field op not refused");
  property p_call; opTaken && op == OP_CALL |=> busy [*2] ##1 !busy; endproperty
  a_call: assert property (p_call) else $error("call stacking length wrong");
  // Third stack write of a break is the status copy with the mark set
  property p_bpush; opTaken && op == OP_SOFTWARE_BREAK |-> ##3 stackBus.write
    && stackBus.wrData[BIT_B]; endproperty
  a_bpush: assert property (p_bpush) else $error("break copy unmarked");
endmodule  // cpuf_registers_check
bind cpuf_registers cpuf_registers_check u_check (.clk(clk), .rst_b(rst_b), .op(op),
  .operand(operand), .stackPage(stackPage), .opTaken(opTaken), .busy(busy),
  .irqAck(irqAck), .illegalOp(illegalOp), .stackBus(stackBus),
  .accumulator(accumulator), .processorStatus(processorStatus), .nzvValid(nzvValid));
`default_nettype wire

// [testbench/cpuf_registers_test.sv]
// Directed test of the core register set and status flags
`default_nettype none
module cpuf_registers_test
  import cpuf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, opValid = 0, idxSel = 0, stackPage = 0, irqReq = 0;
  cpuf_op_e op = OP_NOP;  // Requested operation
  logic [7:0] operand = 0, memAtFirst = 0, stackRdData = 0;
  logic [15:0] target = 0, operandAddr = 0, vectorAddr = 0;
  logic opTaken, busy, irqAck, illegalOp, nzvValid, waiting;
  logic [15:0] indexedAddr, secondOpAddr;
  cpuf_stack_s stackBus;  // Stack port
  cpuf_mem_s memBus;  // Index mode write
  logic [7:0] accumulator, counterHighHalf, counterLowHalf, processorStatus, indexRegSecond;
  int fails = 0, comparisons = 0, cycles = 0, n;
  // Flag operation table: op, flag position, expected value
  cpuf_op_e fo[9] = '{OP_CARRY_SET, OP_CARRY_CLEAR, OP_MASK_OFF, OP_MASK_ON,
    OP_DECIMAL_ON, OP_DECIMAL_OFF, OP_MEM_MODE_ON, OP_MEM_MODE_OFF, OP_OVERFLOW_CLEAR};
  int fb[9] = '{BIT_C, BIT_C, BIT_I, BIT_I, BIT_D, BIT_D, BIT_T, BIT_T, BIT_V};
  logic fv[9] = '{1, 0, 0, 1, 1, 0, 1, 0, 0};
  cpuf_registers dut (.clk(clk), .rst_b(rst_b), .opValid(opValid), .op(op),
    .operand(operand), .target(target), .operandAddr(operandAddr), .idxSel(idxSel),
    .memAtFirst(memAtFirst), .stackPage(stackPage), .stackRdData(stackRdData),
    .irqReq(irqReq), .vectorAddr(vectorAddr), .opTaken(opTaken), .busy(busy),
    .irqAck(irqAck), .illegalOp(illegalOp), .indexedAddr(indexedAddr),
    .secondOpAddr(secondOpAddr), .stackBus(stackBus), .memBus(memBus),
    .accumulator(accumulator), .indexRegFirst(), .indexRegSecond(indexRegSecond), .stackIndex(),
    .counterHighHalf(counterHighHalf), .counterLowHalf(counterLowHalf),
    .processorStatus(processorStatus), .nzvValid(nzvValid), .waiting(waiting), .halted());
  // Free-running core clock, 10 ns period
  always #5 clk = ~clk;
  // Hang guard: far above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Holds the request until taken, releases after the take edge, then settles
  task automatic run(input cpuf_op_e o, input logic [7:0] d);
    n = 0;
    @(negedge clk);
    op = o;
    operand = d;
    opValid = 1'b1;
    #1;
    while (opTaken !== 1'b1 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n == 20) fails++;  // Never accepted
    @(negedge clk);
    opValid = 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    #1;
    chk(processorStatus, STATUS_RESET);
    for (int k = 0; k < 9; k++) begin
      run(fo[k], 8'h00);
      chk(processorStatus[fb[k]], fv[k]);
    end
    $display("flag ops done");
    run(OP_LOAD_ACC, 8'h80);
    chk({accumulator, processorStatus & 8'h82}, 16'h8080);
    run(OP_LOAD_ACC, 8'h7f);
    run(OP_ADD, 8'h01);
    chk({accumulator, processorStatus & 8'hc3}, 16'h80c0);
    run(OP_ADD, 8'h80);
    chk({accumulator, processorStatus & 8'hc3}, 16'h0043);
    run(OP_OVERFLOW_CLEAR, 8'h00);
    chk(processorStatus[BIT_V], 1'b0);
    run(OP_BIT_TEST, 8'h40);
    chk(processorStatus & 8'hc0, 8'h40);
    run(OP_DECIMAL_ON, 8'h00);
    chk(nzvValid, 1'b0);
    run(OP_LOAD_ACC, 8'h09);
    run(OP_CARRY_CLEAR, 8'h00);
    run(OP_ADD, 8'h01);
    chk(accumulator, 8'h10);
    run(OP_LOAD_ACC, 8'h88);
    run(OP_SHIFT_L, 8'h00);
    chk({accumulator, processorStatus[BIT_C]}, 9'h021);
    $display("arithmetic done");
    stackRdData = 8'ha5;
    run(OP_PUSH_ACC, 8'h00);
    run(OP_POP_ACC, 8'h00);
    chk(accumulator, 8'ha5);
    stackRdData = 8'hff;
    run(OP_POP_STATUS, 8'h00);
    chk(processorStatus, 8'hef);
    run(OP_DECIMAL_OFF, 8'h00);
    $display("stack ops done");
    operandAddr = 16'h0100;
    memAtFirst = 8'h10;
    run(OP_LOAD_IDX1, 8'h20);
    chk({indexedAddr, secondOpAddr}, 32'h0120_0020);
    run(OP_LOAD_ACC, 8'h33);
    run(OP_CARRY_CLEAR, 8'h00);
    run(OP_ADD, 8'h05);
    chk(memBus, {16'h0020, 8'h15, 1'b1});
    chk(accumulator, 8'h33);
    run(OP_MEM_MODE_OFF, 8'h00);
    run(OP_FIELD_STORE, 8'h00);
    chk(illegalOp, 1'b1);
    run(OP_FIELD_SHIFT, 8'h00);
    chk(illegalOp, 1'b1);
    $display("index and field ops done");
    run(OP_LOAD_ACC, 8'h10);
    run(OP_PRODUCT, 8'h12);
    chk({indexRegSecond, accumulator}, 16'h0120);
    run(OP_DIVIDE, 8'h10);
    chk({indexRegSecond, accumulator}, 16'h0012);
    run(OP_DIVIDE, 8'h00);
    chk({illegalOp, accumulator}, 9'h112);
    run(OP_CARRY_SET, 8'h00);
    run(OP_SUB, 8'h13);
    chk({accumulator, processorStatus & 8'hc3}, 16'hff80);
    $display("multiply, divide and subtract done");
    vectorAddr = 16'h1234;
    stackPage = 1'b1;
    run(OP_MASK_OFF, 8'h00);
    irqReq = 1'b1;
    n = 0;
    while (irqAck !== 1'b1 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    #1;
    chk(processorStatus[BIT_I], 1'b1);
    run(OP_LOAD_ACC, 8'h01);
    chk({counterHighHalf, counterLowHalf, accumulator}, 24'h123401);
    irqReq = 1'b0;
    target = 16'h4321;
    run(OP_CALL, 8'h00);
    run(OP_NOP, 8'h00);
    chk({counterHighHalf, counterLowHalf}, 16'h4321);
    run(OP_SOFTWARE_BREAK, 8'h00);
    run(OP_NOP, 8'h00);
    chk({counterHighHalf, counterLowHalf}, 16'h1234);
    run(OP_WAIT_INT, 8'h00);
    chk(waiting, 1'b1);
    // A masked request wakes the core without being taken
    irqReq = 1'b1;
    @(negedge clk);
    #1;
    chk({waiting, counterHighHalf, counterLowHalf}, 17'h01234);
    irqReq = 1'b0;
    $display("interrupt and call done");
    print_verdict();
  end
endmodule  // cpuf_registers_test
`default_nettype wire
